/* design/laser_enable_map.svh */
// constants for the laser enable sequencer: timing counts and counter width
// assumes a 10 MHz system clock; includers use the names, never the figures
// Operation
// - keyswitch build: stay disabled after power-up or interlock fault until key off then on
// - over-temperature fault latches in both builds; only a power cycle clears it
// - remote reset acts as the key toggle only while the key is on
// - keyswitch build: reset release powers driver and starts five-second arming timer
// - driver held off while remote reset request is asserted
// - ready output driven closed when lasing possible, released otherwise
// - driver power removed whenever shutter-open is inactive, or ready is inactive outside keyswitch arming
// - OEM build: ready and driver power at power-up if shutter and interlock active
// - OEM build: interlock faults unlatched, ready returns at once
// - OEM build: remote reset is only an inhibit, release restores at once
// - interlock removal drops driver power, shows fault, drops ready
`ifndef LASER_ENABLE_MAP_SVH
`define LASER_ENABLE_MAP_SVH
`define ARM_TIME_MS 5000
`define CLK_PERIOD_NS 100
// ms times cycles-per-ms keeps the product inside 32 bits
`define ARM_CYCLES (`ARM_TIME_MS * (1000000 / `CLK_PERIOD_NS))
`define ARM_CNT_W 26
`endif

/* design/laser_enable_pkg.sv */
// types for the laser enable sequencer
// assumes the map header supplies all figures
package laser_enable_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_KEYOFF = 2'b01,
		ST_ARMING = 2'b11,
		ST_READY = 2'b10
	} seq_state_t;
	typedef struct packed {
		logic key_on;
		logic remote_reset;
		logic shutter_request;
		logic interlock_ok;
		logic over_temp;
	} seq_inputs_t;
	typedef struct packed {
		logic ready_indicator;
		logic shutter_open_indicator;
		logic interlock_fault_indicator;
		logic rf_power_enable;
	} seq_status_t;
endpackage

/* design/laser_enable_sequencer.sv */
// laser enable sequencer: gates rf driver power from key, remote reset, shutter, interlock
// assumes inputs already synchronous to clk_sys and power-up drives reset_n low
`timescale 1ns/1ns
`include "laser_enable_map.svh"
module laser_enable_sequencer (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic variant_oem,
	input wire laser_enable_pkg::seq_inputs_t in_sig,
	output laser_enable_pkg::seq_status_t status,
	output logic ready_out,
	output logic ready_oe
);
	import laser_enable_pkg::*;

	localparam logic [`ARM_CNT_W-1:0] ARM_LAST = `ARM_CNT_W'(`ARM_CYCLES - 1);

	// ****************************************
	// state
	// ****************************************
	seq_state_t state, next_state;
	logic [`ARM_CNT_W-1:0] arm_cnt, next_arm_cnt;
	logic temp_fault, next_temp_fault;
	logic oem, next_oem;
	logic cfg_taken, next_cfg_taken;
	logic ready, next_ready;
	logic rf_on, next_rf_on;
	logic key_seen_off, next_key_seen_off;
	logic qual;

	// qualifiers that must all hold for power to reach the driver
	assign qual = in_sig.interlock_ok & in_sig.shutter_request & ~temp_fault;

	always_comb begin
		next_state = state;
		next_arm_cnt = arm_cnt;
		next_temp_fault = temp_fault | in_sig.over_temp;
		next_oem = oem;
		next_cfg_taken = 1'b1;
		next_key_seen_off = key_seen_off;
		// sampled once after release so a strap glitch later cannot change behaviour
		if (!cfg_taken) begin
			next_oem = variant_oem;
		end
		if (oem) begin
			next_state = ST_IDLE;
			next_arm_cnt = '0;
			next_ready = qual & ~in_sig.remote_reset;
		end else begin
			next_ready = 1'b0;
			case (state)
				ST_IDLE: begin
					// disabled until a key off/on or a remote reset pulse with key on
					if (!in_sig.key_on) begin
						next_key_seen_off = 1'b1;
					end
					if (in_sig.key_on && key_seen_off) begin
						next_key_seen_off = 1'b0;
						next_arm_cnt = '0;
						next_state = ST_ARMING;
					end else if (in_sig.key_on && in_sig.remote_reset) begin
						next_state = ST_KEYOFF;
					end
				end
				ST_KEYOFF: begin
					// holding remote reset counts as key off; release re-arms
					if (!in_sig.key_on) begin
						next_state = ST_IDLE;
						next_key_seen_off = 1'b1;
					end else if (!in_sig.remote_reset) begin
						next_arm_cnt = '0;
						next_state = ST_ARMING;
					end
				end
				ST_ARMING: begin
					if (!in_sig.key_on || !in_sig.interlock_ok || temp_fault) begin
						next_arm_cnt = '0;
						next_state = ST_IDLE;
						next_key_seen_off = ~in_sig.key_on;
					end else if (in_sig.remote_reset || !in_sig.shutter_request) begin
						next_arm_cnt = '0;
						next_state = in_sig.remote_reset ? ST_KEYOFF : ST_ARMING;
					end else if (arm_cnt == ARM_LAST) begin
						next_state = ST_READY;
						next_ready = 1'b1;
					end else begin
						next_arm_cnt = arm_cnt + 1'b1;
					end
				end
				ST_READY: begin
					next_ready = 1'b1;
					if (!in_sig.key_on || !in_sig.interlock_ok || temp_fault) begin
						next_ready = 1'b0; // latched fault needs a fresh arm
						next_state = ST_IDLE;
						next_key_seen_off = ~in_sig.key_on;
					end else if (in_sig.remote_reset) begin
						next_ready = 1'b0;
						next_state = ST_KEYOFF;
					end else if (!in_sig.shutter_request) begin
						next_ready = 1'b0;
						next_arm_cnt = '0;
						next_state = ST_ARMING; // shutter reopen waits the delay again
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
		// power follows ready or arming, gated by the qualifiers and remote reset; arming powers the driver but not lasing
		next_rf_on = ((oem ? next_ready : (next_ready | next_state == ST_ARMING)) & qual) & ~in_sig.remote_reset;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			arm_cnt <= '0;
			temp_fault <= 1'b0;
			oem <= 1'b0;
			cfg_taken <= 1'b0;
			ready <= 1'b0;
			rf_on <= 1'b0;
			key_seen_off <= 1'b0;
		end else begin
			state <= next_state;
			arm_cnt <= next_arm_cnt;
			temp_fault <= next_temp_fault;
			oem <= next_oem;
			cfg_taken <= next_cfg_taken;
			ready <= next_ready;
			rf_on <= next_rf_on;
			key_seen_off <= next_key_seen_off;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign status.ready_indicator = ready;
	assign status.shutter_open_indicator = rf_on;
	assign status.interlock_fault_indicator = ~in_sig.interlock_ok;
	assign status.rf_power_enable = rf_on;
	// open-collector: drive low when ready, release otherwise
	assign ready_out = 1'b0;
	assign ready_oe = ready;

	// ****************************************
	// checks
	// ****************************************
	sequence s_reset_held;
		in_sig.remote_reset [*2];
	endsequence

	chk_reset_blocks_rf: assert property (@(posedge clk_sys) disable iff (!reset_n)
		in_sig.remote_reset |=> !rf_on) else $error("rf on while remote reset held");
	chk_reset_hold_rf: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_reset_held |-> !rf_on) else $error("rf on during held reset");
	chk_rf_needs_qual: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!in_sig.shutter_request |=> !rf_on) else $error("rf on with shutter closed");
	chk_interlock_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!in_sig.interlock_ok |=> !ready && !rf_on) else $error("ready with interlock open");
	chk_temp_latched: assert property (@(posedge clk_sys) disable iff (!reset_n)
		in_sig.over_temp |=> temp_fault) else $error("temp fault not latched");
	chk_temp_kills_ready: assert property (@(posedge clk_sys) disable iff (!reset_n)
		temp_fault |=> !ready) else $error("ready with temp fault");
	chk_oem_immediate: assert property (@(posedge clk_sys) disable iff (!reset_n)
		oem && cfg_taken && $past(oem) && qual && !in_sig.remote_reset |=> ready)
		else $error("oem ready delayed");
	chk_ready_oe: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ready_oe == ready && !ready_out) else $error("ready pin mismatch");
	chk_key_arm_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!oem && !$past(ready) && ready |-> $past(state) == ST_ARMING && $past(arm_cnt) == ARM_LAST)
		else $error("keyswitch ready without full delay");
	chk_arm_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
		state == ST_ARMING && in_sig.remote_reset |=> arm_cnt == '0) else $error("timer not restarted");
	chk_variant_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		cfg_taken |=> $stable(oem)) else $error("variant changed");
endmodule // laser_enable_sequencer

/* verification/plc_model.sv */
// system controller model: replays commanded request levels onto the sequencer inputs
// assumes the bench changes cmd just after a rising edge
`timescale 1ns/1ns
module plc_model (
	input wire logic clk_sys,
	input wire laser_enable_pkg::seq_inputs_t cmd,
	output laser_enable_pkg::seq_inputs_t in_sig
);
	import laser_enable_pkg::*;
	initial in_sig = '0;
	// levels move on the falling edge, clear of the sampling edge
	always @(negedge clk_sys) begin
		in_sig <= cmd;
	end
endmodule // plc_model

/* verification/laser_enable_sequencer_tb_top.sv */
// testbench for the laser enable sequencer, keyswitch and oem builds
// assumes the full arming delay is far beyond the run, so only its start is seen
`timescale 1ns/1ns
module laser_enable_sequencer_tb_top;
	import laser_enable_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic variant_oem = 1'b0;
	seq_inputs_t cmd = '0;
	seq_inputs_t in_sig;
	seq_status_t status;
	logic ready_out;
	logic ready_oe;
	int mismatches = 0;
	int tests_run = 0;
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	plc_model i_plc_model (.clk_sys(clk_sys), .cmd(cmd), .in_sig(in_sig));
	laser_enable_sequencer i_laser_enable_sequencer (.clk_sys(clk_sys), .reset_n(reset_n),
		.variant_oem(variant_oem), .in_sig(in_sig), .status(status), .ready_out(ready_out), .ready_oe(ready_oe));
	// ****************
	// helpers
	// ****************
	task automatic chk(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %b, seen %b", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic lasing(input logic exp);
		chk("ready_oe", ready_oe, exp);
		chk("ready_indicator", status.ready_indicator, exp);
		chk("rf_power_enable", status.rf_power_enable, exp);
	endtask
	task automatic do_reset(input logic v);
		@(negedge clk_sys);
		reset_n = 1'b0;
		variant_oem = v;
		repeat (16) @(negedge clk_sys);
		reset_n = 1'b1;
		cyc(4);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic test_keyswitch;
		cmd = 5'h16;
		do_reset(1'b0);
		cyc(20);
		lasing(1'b0);
		chk("ready_out", ready_out, 1'b0);
		cmd.key_on = 1'b0;
		cyc(3);
		cmd.remote_reset = 1'b1;
		cyc(3);
		cmd.remote_reset = 1'b0;
		cyc(4);
		chk("rf_power_enable", status.rf_power_enable, 1'b0);
		cmd.key_on = 1'b1;
		cyc(4);
		chk("rf_power_enable", status.rf_power_enable, 1'b1);
		cmd.remote_reset = 1'b1;
		cyc(4);
		chk("rf_power_enable", status.rf_power_enable, 1'b0);
		cmd.remote_reset = 1'b0;
		cyc(1000);
		chk("rf_power_enable", status.rf_power_enable, 1'b1);
		chk("ready_oe", ready_oe, 1'b0);
		cmd.shutter_request = 1'b0;
		cyc(3);
		chk("shutter_open_indicator", status.shutter_open_indicator, 1'b0);
		cmd.shutter_request = 1'b1;
		cyc(3);
		chk("ready_indicator", status.ready_indicator, 1'b0);
		cmd.interlock_ok = 1'b0;
		cyc(3);
		chk("interlock_fault_indicator", status.interlock_fault_indicator, 1'b1);
		cmd.interlock_ok = 1'b1;
		cyc(5);
		chk("rf_power_enable", status.rf_power_enable, 1'b0);
		$display("keyswitch test done");
	endtask
	task automatic test_oem;
		cmd = 5'h16;
		do_reset(1'b1);
		@(negedge clk_sys);
		variant_oem = 1'b0;
		cyc(2);
		lasing(1'b1);
		cmd.remote_reset = 1'b1;
		cyc(3);
		lasing(1'b0);
		cmd.remote_reset = 1'b0;
		cyc(3);
		lasing(1'b1);
		cmd.interlock_ok = 1'b0;
		cyc(3);
		lasing(1'b0);
		cmd.interlock_ok = 1'b1;
		cyc(3);
		lasing(1'b1);
		cmd.over_temp = 1'b1;
		cyc(3);
		cmd.over_temp = 1'b0;
		cmd.remote_reset = 1'b1;
		cyc(3);
		cmd.remote_reset = 1'b0;
		cyc(4);
		lasing(1'b0);
		$display("oem test done");
	endtask
	// ****************
	// sequence and watchdog
	// ****************
	initial begin
		test_keyswitch();
		test_oem();
		print_verdict();
	end
	initial begin
		#(5000 * 100);
		mismatches++;
		print_verdict();
	end
endmodule // laser_enable_sequencer_tb_top
